// ---- hdl/ffbc_map.svh ----
// Offsets-free constant map for the flip-flop binary counter
`ifndef FFBC_MAP_SVH
`define FFBC_MAP_SVH
`define FFBC_STAGES 4
`define FFBC_ZERO 4'h0
`define FFBC_BCD_MAX 4'h9
`define FFBC_LATCH_RST 1'b0
`endif

// ---- hdl/ffbc_pkg.sv ----
// Types for the flip-flop binary counter
package ffbc_pkg;
  typedef logic [3:0] ffbc_cnt_t;
  typedef struct packed {
    logic set_p;
    logic rst_p;
  } ffbc_sr_t;
  typedef struct packed {
    logic j;
    logic k;
    logic jk_open;
  } ffbc_steer_t;
  typedef enum logic {FFBC_IDLE, FFBC_SEEN} ffbc_edge_t;
  typedef struct packed {
    logic [1:0] trig_sync;
    logic trig_prev;
    logic [1:0] rst_sync;
    logic [1:0] set_sync;
    logic [1:0] tst_sync;
    logic tst_prev;
    logic [1:0] jk_sync;
    logic jk_prev;
    logic latch_q;
    logic tog_q;
    logic sr_q;
    logic rst_stage_q;
    logic jk_q;
    ffbc_cnt_t cnt;
    ffbc_edge_t edge_st;
  } ffbc_state_t;
endpackage : ffbc_pkg

// ---- hdl/ffbc_counter.sv ----
// Flip-flop stages and four-stage ripple binary counter
`timescale 1ns/1ps
`include "ffbc_map.svh"

// Notes on behaviour
// - Latch holds last set or reset; opposite input reverses it.
// - Toggle stage inverts on each falling trigger, halving the rate.
// - Set/reset stage ignores repeated set; reset holds until next set.
// - Combined stage toggles on falling trigger; set/reset act on high.
// - Combined set drives inverted output high; reset drives true high.
// - Clocked stage with both steering high toggles each clock pulse.
// - Set-steer high, clear-steer low: clock drives true output high.
// - Set-steer low, clear-steer high: clock drives inverted high.
// - Both steering low: clock pulses ignored, state held.
// - Unconnected steering inputs act as both high, toggling.
// - Counter stages have clear, preset and blanking inputs.
// - Four stages chained; each acts only on falling trigger.
// - Stage weights 1, 2, 4, 8; count is sum of set weights.
// - Set stage shows true output high; all start at zero.
// - From seven, next input clears low three and sets fourth.
// - Chain cycles through 16 states, wrapping to zero.
// - Clear returns every stage to zero before a new count.
// - Decimal digit valid only for codes 0000 through 1001.
// - Latch outputs complementary; direct reset holds it cleared.
module ffbc_counter (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clear,
  input wire logic preset,
  input wire ffbc_pkg::ffbc_cnt_t preset_val,
  input wire logic blank,
  input wire logic trig,
  input wire ffbc_pkg::ffbc_sr_t latch_in,
  input wire logic latch_direct_rst,
  input wire ffbc_pkg::ffbc_sr_t sr_in,
  input wire ffbc_pkg::ffbc_sr_t rst_in,
  input wire logic rst_trig,
  input wire ffbc_pkg::ffbc_steer_t steer,
  input wire logic jk_clk,
  output logic latch_q,
  output logic latch_qn,
  output logic tog_q,
  output logic sr_q,
  output logic rst_stage_q,
  output logic rst_stage_qn,
  output logic jk_q,
  output logic jk_qn,
  output ffbc_pkg::ffbc_cnt_t count,
  output logic digit_valid,
  output logic blank_out
);
  import ffbc_pkg::*;

  ffbc_state_t st;
  ffbc_state_t next_st;
  logic arst_n;
  logic trig_fall;
  logic tst_fall;
  logic jk_fall;
  logic j_eff;
  logic k_eff;
  logic [`FFBC_STAGES:0] ripple;
  ffbc_cnt_t next_cnt;

  // Clear acts as asynchronous reset of all stages
  assign arst_n = rstn & ~clear;

  assign trig_fall = st.trig_prev & ~st.trig_sync[1];
  assign tst_fall = st.tst_prev & ~st.tst_sync[1];
  assign jk_fall = st.jk_prev & ~st.jk_sync[1];
  assign j_eff = steer.jk_open | steer.j;
  assign k_eff = steer.jk_open | steer.k;

  // Ripple chain: each stage toggles on the fall of the one before
  assign ripple[0] = trig_fall;
  genvar gi;
  generate
    for (gi = 0; gi < `FFBC_STAGES; gi++) begin : g_stage
      assign next_cnt[gi] = st.cnt[gi] ^ ripple[gi];
      assign ripple[gi+1] = ripple[gi] & st.cnt[gi];
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.trig_sync = {st.trig_sync[0], trig};
    next_st.trig_prev = st.trig_sync[1];
    next_st.rst_sync = {st.rst_sync[0], latch_direct_rst};
    next_st.set_sync = {st.set_sync[0], 1'b0};
    next_st.tst_sync = {st.tst_sync[0], rst_trig};
    next_st.tst_prev = st.tst_sync[1];
    next_st.jk_sync = {st.jk_sync[0], jk_clk};
    next_st.jk_prev = st.jk_sync[1];
    next_st.edge_st = trig_fall ? FFBC_SEEN : FFBC_IDLE;
    // Basic latch
    if (latch_direct_rst) begin
      next_st.latch_q = `FFBC_LATCH_RST;
    end else if (latch_in.set_p && !latch_in.rst_p) begin
      next_st.latch_q = 1'b1;
    end else if (latch_in.rst_p && !latch_in.set_p) begin
      next_st.latch_q = 1'b0;
    end
    // Toggle stage
    if (trig_fall) begin
      next_st.tog_q = ~st.tog_q;
    end
    // Set/reset stage
    if (sr_in.rst_p) begin
      next_st.sr_q = 1'b0;
    end else if (sr_in.set_p) begin
      next_st.sr_q = 1'b1;
    end
    // Combined set/reset/toggle stage
    if (rst_in.set_p) begin
      next_st.rst_stage_q = 1'b0;
    end else if (rst_in.rst_p) begin
      next_st.rst_stage_q = 1'b1;
    end else if (tst_fall) begin
      next_st.rst_stage_q = ~st.rst_stage_q;
    end
    // Clocked steering stage with preset
    if (preset) begin
      next_st.jk_q = 1'b1;
    end else if (jk_fall) begin
      case ({j_eff, k_eff})
        2'b11: next_st.jk_q = ~st.jk_q;
        2'b10: next_st.jk_q = 1'b1;
        2'b01: next_st.jk_q = 1'b0;
        2'b00: next_st.jk_q = st.jk_q;
        default: next_st.jk_q = st.jk_q;
      endcase
    end
    // Counter chain
    case (st.edge_st)
      FFBC_IDLE, FFBC_SEEN: begin
        if (preset) begin
          next_st.cnt = preset_val;
        end else begin
          next_st.cnt = next_cnt;
        end
      end
      default: next_st.cnt = st.cnt;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign latch_q = st.latch_q;
  assign latch_qn = ~st.latch_q;
  assign tog_q = st.tog_q;
  assign sr_q = st.sr_q;
  assign rst_stage_q = st.rst_stage_q;
  assign rst_stage_qn = ~st.rst_stage_q;
  assign jk_q = st.jk_q;
  assign jk_qn = ~st.jk_q;
  assign count = st.cnt;
  assign digit_valid = (st.cnt <= `FFBC_BCD_MAX);
  assign blank_out = blank;

  chk_ripple_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
    trig_fall && !preset |=> st.cnt == $past(st.cnt) + 4'h1)
    else $error("count did not step on falling trigger");
  chk_hold_no_edge: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !trig_fall && !preset |=> $stable(st.cnt))
    else $error("count moved without trigger");
  chk_carry_seven: assert property (@(posedge clk_sys) disable iff (!arst_n)
    trig_fall && !preset && st.cnt == 4'h7 |=> st.cnt == 4'h8)
    else $error("carry from seven wrong");
  chk_wrap_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    trig_fall && !preset && st.cnt == 4'hF |=> st.cnt == 4'h0)
    else $error("count did not wrap");
  chk_preset_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
    preset |=> st.cnt == $past(preset_val))
    else $error("preset not loaded");
  chk_toggle_stage: assert property (@(posedge clk_sys) disable iff (!arst_n)
    trig_fall |=> tog_q != $past(tog_q))
    else $error("toggle stage did not invert");
  chk_jk_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    jk_fall && !preset && !j_eff && !k_eff |=> $stable(jk_q))
    else $error("steering stage moved with both low");
  chk_jk_toggle: assert property (@(posedge clk_sys) disable iff (!arst_n)
    jk_fall && !preset && j_eff && k_eff |=> jk_q != $past(jk_q))
    else $error("steering stage did not toggle");
  chk_jk_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    jk_fall && !preset && j_eff && !k_eff |=> jk_q)
    else $error("steering stage not set");
  chk_jk_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    jk_fall && !preset && !j_eff && k_eff |=> jk_qn)
    else $error("steering stage not cleared");
  chk_latch_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !latch_direct_rst && latch_in == 2'h2 |=> latch_q)
    else $error("latch not set");
  chk_sr_reset: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sr_in.rst_p |=> !sr_q)
    else $error("reset pulse did not clear stage");
  chk_rst_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rst_in.set_p |=> rst_stage_qn)
    else $error("combined set did not raise inverted output");
  chk_latch_drst: assert property (@(posedge clk_sys) disable iff (!arst_n)
    latch_direct_rst |=> !latch_q && latch_qn)
    else $error("direct reset did not clear latch");
  chk_digit_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
    digit_valid == (count < 4'hA))
    else $error("digit valid flag wrong");

  cov_wrap: cover property (@(posedge clk_sys) disable iff (!arst_n)
    trig_fall && st.cnt == 4'hF);
  cov_seven: cover property (@(posedge clk_sys) disable iff (!arst_n)
    trig_fall && st.cnt == 4'h7);
  cov_preset: cover property (@(posedge clk_sys) disable iff (!arst_n)
    preset);
  cov_jk_toggle: cover property (@(posedge clk_sys) disable iff (!arst_n)
    jk_fall && j_eff && k_eff);
endmodule : ffbc_counter

// ---- dv/ffbc_pulse_src.sv ----
// Upstream pulse source driving the counter trigger
`timescale 1ns/1ps
module ffbc_pulse_src (
  input wire logic clk_sys,
  input wire logic fire,
  output logic trig,
  output logic busy
);
  logic [3:0] tick = 4'h0;
  initial trig = 1'b1;
  assign busy = (tick != 4'h0);
  always @(posedge clk_sys) begin
    if (fire && !busy) tick <= 4'h8;
    else if (busy) tick <= tick - 4'h1;
    trig <= !(tick > 4'h4);
  end
endmodule : ffbc_pulse_src

// ---- dv/ffbc_counter_tb_top.sv ----
// Testbench for the flip-flop binary counter
`timescale 1ns/1ps
module ffbc_counter_tb_top;
  import ffbc_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, clear = 1'b0, preset = 1'b0;
  logic blank = 1'b0, fire = 1'b0, ldr = 1'b0, jk_clk = 1'b1, rtr = 1'b1;
  ffbc_cnt_t pv = 4'h0, cnt;
  ffbc_sr_t li = 2'h0, si = 2'h0, ri = 2'h0;
  ffbc_steer_t st = 3'h0;
  logic trig, busy, lq, lqn, tq, sq, rq, rqn, jq, jqn, dv, bo;
  int bad_count = 0, total_checks = 0, m = 0, t = 0, j = 0;
  logic [2:0] jc [5] = '{3'h4, 3'h0, 3'h2, 3'h6, 3'h1};
  always #12.5 clk_sys = ~clk_sys;
  ffbc_pulse_src u_ffbc_pulse_src (.clk_sys(clk_sys), .fire(fire),
    .trig(trig), .busy(busy));
  ffbc_counter u_ffbc_counter (.clk_sys(clk_sys), .rstn(rstn),
    .clear(clear), .preset(preset), .preset_val(pv), .blank(blank),
    .trig(trig), .latch_in(li), .latch_direct_rst(ldr), .sr_in(si),
    .rst_in(ri), .rst_trig(rtr), .steer(st), .jk_clk(jk_clk),
    .latch_q(lq), .latch_qn(lqn), .tog_q(tq), .sr_q(sq),
    .rst_stage_q(rq), .rst_stage_qn(rqn), .jk_q(jq), .jk_qn(jqn),
    .count(cnt), .digit_valid(dv), .blank_out(bo));
  task step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step
  task look;
    step(4);
    @(negedge clk_sys);
  endtask : look
  task chk(input string s, input logic [3:0] e, input logic [3:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task pulse;
    step(1);
    fire <= 1'b1;
    step(1);
    fire <= 1'b0;
    step(1);
    for (int i = 0; i < 30 && busy; i++) step(1);
    if (busy) begin
      bad_count++;
      end_of_test;
    end
    m = (m + 1) % 16;
    t ^= 1;
    look;
    chk("count", m, cnt);
    chk("tog", t, tq);
    chk("valid", m <= 9, dv);
  endtask : pulse
  task fall(input bit w);
    step(1);
    if (w) jk_clk <= 1'b0; else rtr <= 1'b0;
    step(4);
    if (w) jk_clk <= 1'b1; else rtr <= 1'b1;
    look;
  endtask : fall
  task drv(input logic [1:0] l, input logic [1:0] s, input logic [1:0] r);
    step(1);
    li <= l;
    si <= s;
    ri <= r;
    step(3);
    li <= 2'h0;
    si <= 2'h0;
    ri <= 2'h0;
    look;
  endtask : drv
  initial begin
    void'($urandom(82856));
    step(5);
    rstn <= 1'b1;
    look;
    chk("count", 0, cnt);
    chk("latchn", 1, lqn);
    for (int i = 0; i < 20; i++) pulse();
    drv(2'h2, 2'h2, 2'h2);
    chk("latch", 1, lq);
    chk("sr", 1, sq);
    chk("rst", 0, rq);
    chk("rstn", 1, rqn);
    drv(2'h1, 2'h2, 2'h1);
    chk("latch", 0, lq);
    chk("sr", 1, sq);
    chk("rst", 1, rq);
    drv(2'h2, 2'h1, 2'h0);
    chk("sr", 0, sq);
    fall(0);
    chk("rst", 0, rq);
    step(1);
    ldr <= 1'b1;
    drv(2'h2, 2'h0, 2'h0);
    chk("latch", 0, lq);
    step(1);
    ldr <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      step(1);
      st <= jc[k];
      fall(1);
      if (jc[k][0] || jc[k][2:1] == 2'h3) j ^= 1;
      else if (jc[k][2:1] != 2'h0) j = jc[k][2];
      chk("jk", j, jq);
      chk("jkn", !j, jqn);
    end
    step(1);
    pv <= 4'($urandom);
    preset <= 1'b1;
    blank <= 1'b1;
    step(1);
    preset <= 1'b0;
    look;
    m = pv;
    chk("count", m, cnt);
    chk("jk", 1, jq);
    chk("blank", 1, bo);
    pulse();
    step(1);
    preset <= 1'b1;
    clear <= 1'b1;
    blank <= 1'b0;
    look;
    chk("count", 0, cnt);
    chk("tog", 0, tq);
    chk("blank", 0, bo);
    end_of_test;
  end
endmodule : ffbc_counter_tb_top
